// ===== src/ctm_defs.svh
// Compact timer constants: encodings, reset values and divider ratios
`ifndef CTM_DEFS_SVH
`define CTM_DEFS_SVH

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define CTM_CNT_W 10
`define CTM_P_W 3
`define CTM_BYTE_W 8
`define CTM_CNT_RST 10'h000
`define CTM_COMPARE_A_VALUE_RST 10'h000
`define CTM_BUF_RST 8'h00

// ****************************************************************
// Byte access selectors (byte addresses of the access port)
// ****************************************************************
`define CTM_SEL_CNT_LO 2'h0
`define CTM_SEL_CNT_HI 2'h1
`define CTM_SEL_CMP_LO 2'h2
`define CTM_SEL_CMP_HI 2'h3

// ****************************************************************
// Clock select field codes
// ****************************************************************
`define CTM_CK_SYS_DIV4 3'h0
`define CTM_CK_SYS 3'h1
`define CTM_CK_H_DIV16 3'h2
`define CTM_CK_H_DIV64 3'h3
`define CTM_CK_SUB_A 3'h4
`define CTM_CK_SUB_B 3'h5
`define CTM_CK_EVT_RISE 3'h6
`define CTM_CK_EVT_FALL 3'h7

// ****************************************************************
// Divider ratios (terminal masks of the free divider)
// ****************************************************************
`define CTM_DIV_W 6
`define CTM_DIV4_MASK 6'h03
`define CTM_DIV16_MASK 6'h0f
`define CTM_DIV64_MASK 6'h3f

// ****************************************************************
// Operating modes and output actions
// ****************************************************************
`define CTM_MODE_CMP 2'h0
`define CTM_MODE_UNDEF 2'h1
`define CTM_MODE_PWM 2'h2
`define CTM_MODE_TIMER 2'h3
`define CTM_IO_NONE 2'h0
`define CTM_IO_LOW 2'h1
`define CTM_IO_HIGH 2'h2
`define CTM_IO_TOGGLE 2'h3
`define CTM_PWM_INACTIVE 2'h0
`define CTM_PWM_ACTIVE 2'h1
`define CTM_PWM_WAVE 2'h2

`endif

// ===== src/ctm_pkg.sv
// Compact timer types
`include "ctm_defs.svh"
package ctm_pkg;
    typedef enum logic [1:0] {
        CTM_MODE_CMP_E = `CTM_MODE_CMP,
        CTM_MODE_UNDEF_E = `CTM_MODE_UNDEF,
        CTM_MODE_PWM_E = `CTM_MODE_PWM,
        CTM_MODE_TIMER_E = `CTM_MODE_TIMER
    } ctm_mode_t;
    typedef enum logic [1:0] {
        CTM_SEL_CNT_LO_E = `CTM_SEL_CNT_LO,
        CTM_SEL_CNT_HI_E = `CTM_SEL_CNT_HI,
        CTM_SEL_CMP_LO_E = `CTM_SEL_CMP_LO,
        CTM_SEL_CMP_HI_E = `CTM_SEL_CMP_HI
    } ctm_byte_sel_t;
endpackage : ctm_pkg

// ===== src/ctm_byte_if.sv
// Byte access carrier between timer core and shadow buffer port
`timescale 1ns/1ns
`include "ctm_defs.svh"
interface ctm_byte_if #(
    parameter int CNT_W = `CTM_CNT_W
);
    import ctm_pkg::*;
    logic ce;
    logic wr;
    logic rd;
    ctm_byte_sel_t sel;
    logic [`CTM_BYTE_W-1:0] wdata;
    logic [`CTM_BYTE_W-1:0] rdata;
    logic rvalid;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] compare_a_value;
    modport core (
        output ce, wr, rd, sel, wdata, count,
        input rdata, rvalid, compare_a_value
    );
    modport port (
        input ce, wr, rd, sel, wdata, count,
        output rdata, rvalid, compare_a_value
    );
endinterface : ctm_byte_if

// ===== src/ctm_byte_port.sv
// Byte access port with shared 8-bit low-byte shadow buffer
`timescale 1ns/1ns
`include "ctm_defs.svh"
module ctm_byte_port
    import ctm_pkg::*;
#(
    parameter int CNT_W = `CTM_CNT_W
) (
    input wire logic sys_clk_in,   // System clock
    input wire logic nrst_in,      // Synchronous reset, active low
    ctm_byte_if.port acc           // Byte access carrier
);
    logic [`CTM_BYTE_W-1:0] shadow;
    logic [`CTM_BYTE_W-1:0] rdata;
    logic rvalid;
    logic [CNT_W-1:0] compare_a_value;

    assign acc.rdata = rdata;
    assign acc.rvalid = rvalid;
    assign acc.compare_a_value = compare_a_value;

    // ****************************************************************
    // Shadow buffer and compare A storage
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            shadow <= `CTM_BUF_RST;
            compare_a_value <= `CTM_COMPARE_A_VALUE_RST;
        end else if (acc.ce) begin
            if (acc.wr) begin
                case (acc.sel)
                    CTM_SEL_CMP_LO_E: shadow <= acc.wdata;
                    CTM_SEL_CMP_HI_E: begin
                        compare_a_value <= CNT_W'({acc.wdata, shadow});
                    end
                    default: ;
                endcase
            end else if (acc.rd) begin
                case (acc.sel)
                    CTM_SEL_CNT_HI_E: begin
                        shadow <= acc.count[`CTM_BYTE_W-1:0];
                    end
                    CTM_SEL_CMP_HI_E: begin
                        shadow <= compare_a_value[`CTM_BYTE_W-1:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            rdata <= `CTM_BUF_RST;
            rvalid <= 1'b0;
        end else if (acc.ce) begin
            rvalid <= acc.rd & ~acc.wr;
            if (acc.rd && !acc.wr) begin
                case (acc.sel)
                    CTM_SEL_CNT_HI_E: begin
                        rdata <= `CTM_BYTE_W'(acc.count >> `CTM_BYTE_W);
                    end
                    CTM_SEL_CMP_HI_E: begin
                        rdata <= `CTM_BYTE_W'(compare_a_value >> `CTM_BYTE_W);
                    end
                    default: rdata <= shadow;
                endcase
            end
        end
    end
endmodule : ctm_byte_port

// ===== src/ctm_prescale.sv
// Counter clock selection: divided clocks and synchronised pin edges
`timescale 1ns/1ns
`include "ctm_defs.svh"
module ctm_prescale
    import ctm_pkg::*;
(
    input wire logic sys_clk_in,      // System clock
    input wire logic nrst_in,         // Synchronous reset, active low
    input wire logic ce_in,           // Clock enable
    input wire logic [2:0] clk_sel_in, // Clock select field
    input wire logic sub_clk_in,      // Sub clock, asynchronous
    input wire logic event_pin_in,    // Event clock pin, asynchronous
    output logic tick_out             // One-cycle counter advance
);
    logic [`CTM_DIV_W-1:0] div;
    logic [2:0] sub_sync;
    logic [2:0] evt_sync;
    logic sub_rise;
    logic evt_rise;
    logic evt_fall;

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            div <= '0;
        end else if (ce_in) begin
            div <= `CTM_DIV_W'(div + 1'b1);
        end
    end

    // Stage 0 feeds only stage 1; edges look at stages 1 and 2
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            sub_sync <= 3'h0;
            evt_sync <= 3'h0;
        end else if (ce_in) begin
            sub_sync <= {sub_sync[1:0], sub_clk_in};
            evt_sync <= {evt_sync[1:0], event_pin_in};
        end
    end

    assign sub_rise = sub_sync[1] & ~sub_sync[2];
    assign evt_rise = evt_sync[1] & ~evt_sync[2];
    assign evt_fall = ~evt_sync[1] & evt_sync[2];

    always_comb begin
        case (clk_sel_in)
            `CTM_CK_SYS_DIV4: begin
                tick_out = (div & `CTM_DIV4_MASK) == `CTM_DIV4_MASK;
            end
            `CTM_CK_SYS: tick_out = 1'b1;
            `CTM_CK_H_DIV16: begin
                tick_out = (div & `CTM_DIV16_MASK) == `CTM_DIV16_MASK;
            end
            `CTM_CK_H_DIV64: tick_out = div == `CTM_DIV64_MASK;
            `CTM_CK_SUB_A: tick_out = sub_rise;
            `CTM_CK_SUB_B: tick_out = sub_rise;
            `CTM_CK_EVT_RISE: tick_out = evt_rise;
            `CTM_CK_EVT_FALL: tick_out = evt_fall;
            default: tick_out = 1'b0;
        endcase
    end
endmodule : ctm_prescale

// ===== src/ctm_top.sv
// Compact timer core: counter, comparators, output pins, byte access
// Functional notes
// - Clock select field picks full or divided system, divided high, sub or pin clock.
// - Event pin counts on its rising or falling edge, as selected.
// - Event pin feeds the counter only when the select field picks it.
// - Counter equal to a comparator raises a request, may clear, may drive pin.
// - Separate requests for comparator A and comparator P matches.
// - Compare output mode drives pins high, low or toggles on match.
// - Primary output pin carries the waveform in PWM mode.
// - Three modes: compare match output, timer/event counter, PWM.
// - Low bytes are reached only through one 8-bit shadow buffer.
// - Low compare write fills buffer; high write stores both bytes together.
// - High read returns directly and captures low byte into the buffer.
// - Counter is a 10-bit up-counter; comparator A checks all ten bits.
// - Comparator P holds three bits compared with the top counter bits.
// - Counter clears only on reset, run rising, overflow or a match of the comparator picked by clr_on_a_in.
`timescale 1ns/1ns
`include "ctm_defs.svh"
module ctm_top
    import ctm_pkg::*;
#(
    parameter int CNT_W = `CTM_CNT_W,
    parameter int P_W = `CTM_P_W
) (
    input wire logic sys_clk_in,         // System clock, 20 MHz
    input wire logic nrst_in,            // Synchronous reset, active low
    input wire logic ce_in,              // Clock enable, freezes state
    input wire logic counter_run_bit_in, // Counter run control
    input wire logic pause_in,           // Counter pause
    input wire logic [2:0] clock_select_field_in, // Counter clock source
    input wire logic [P_W-1:0] compare_p_value_in, // Comparator P value
    input wire logic [1:0] mode_in,      // Operating mode
    input wire logic [1:0] out_func_in,  // Output function select
    input wire logic out_ctrl_in,        // Initial level / active level
    input wire logic out_pol_in,         // Output pin polarity invert
    input wire logic clr_on_a_in,        // Clear on A match (else on P)
    input wire logic sub_clk_in,         // Sub clock, asynchronous
    input wire logic event_clock_pin_in, // Event clock pin, asynchronous
    input wire logic acc_wr_in,          // Byte write strobe
    input wire logic acc_rd_in,          // Byte read strobe
    input wire logic [1:0] acc_sel_in,   // Byte selector
    input wire logic [7:0] acc_wdata_in, // Byte write data
    output logic [7:0] acc_rdata_out,    // Byte read data
    output logic acc_rvalid_out,         // Read data valid pulse
    output logic irq_a_out,              // Comparator A match pulse
    output logic irq_p_out,              // Comparator P match pulse
    output logic timer_out_pin_out,      // Primary output pin
    output logic timer_out_pin_inverted_out, // Inverted output pin
    output logic [CNT_W-1:0] count_out   // Counter value
);
    localparam int LOW_W = CNT_W - P_W;

    ctm_byte_if #(.CNT_W(CNT_W)) acc_if ();

    ctm_mode_t mode;
    logic tick;
    logic run_q;
    logic run_rise;
    logic advance;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] after_count;
    logic match_a;
    logic match_p;
    logic clr_now;
    logic out_q;
    logic next_out;
    logic pwm_on;
    logic irq_a;
    logic irq_p;
    logic pin;
    logic pin_inv;

    assign mode = ctm_mode_t'(mode_in);

    // ****************************************************************
    // Counter clock source
    // ****************************************************************
    ctm_prescale u_prescale (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .clk_sel_in(clock_select_field_in),
        .sub_clk_in(sub_clk_in),
        .event_pin_in(event_clock_pin_in),
        .tick_out(tick)
    );

    // ****************************************************************
    // Byte access through the shadow buffer
    // ****************************************************************
    assign acc_if.ce = ce_in;
    assign acc_if.wr = acc_wr_in;
    assign acc_if.rd = acc_rd_in;
    assign acc_if.sel = ctm_byte_sel_t'(acc_sel_in);
    assign acc_if.wdata = acc_wdata_in;
    assign acc_if.count = count;
    assign acc_rdata_out = acc_if.rdata;
    assign acc_rvalid_out = acc_if.rvalid;

    ctm_byte_port #(.CNT_W(CNT_W)) u_byte_port (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .acc(acc_if.port)
    );

    // ****************************************************************
    // Run edge detection
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            run_q <= 1'b0;
        end else if (ce_in) begin
            run_q <= counter_run_bit_in;
        end
    end

    assign run_rise = counter_run_bit_in & ~run_q;
    assign advance = tick & counter_run_bit_in & ~pause_in & ~run_rise;

    // ****************************************************************
    // Comparators
    // ****************************************************************
    assign next_count = CNT_W'(count + 1'b1);
    assign match_a = next_count == acc_if.compare_a_value;
    // Value zero of P matches on wrap, i.e. overflow
    assign match_p = (next_count[CNT_W-1:LOW_W] == compare_p_value_in)
        && (next_count[LOW_W-1:0] == '0);
    assign clr_now = clr_on_a_in ? match_a : match_p;
    assign after_count = clr_now ? '0 : next_count;

    // ****************************************************************
    // Counter
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            count <= `CTM_CNT_RST;
        end else if (ce_in) begin
            if (run_rise) begin
                count <= '0;
            end else if (advance) begin
                count <= after_count;
            end
        end
    end

    assign count_out = count;

    // ****************************************************************
    // Match requests
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            irq_a <= 1'b0;
            irq_p <= 1'b0;
        end else if (ce_in) begin
            irq_a <= advance & match_a;
            irq_p <= advance & match_p;
        end
    end

    assign irq_a_out = irq_a;
    assign irq_p_out = irq_p;

    // ****************************************************************
    // Output level
    // ****************************************************************
    assign pwm_on = after_count < acc_if.compare_a_value;

    always_comb begin
        next_out = out_q;
        case (mode)
            CTM_MODE_CMP_E: begin
                if (advance && match_a) begin
                    case (out_func_in)
                        `CTM_IO_LOW: next_out = 1'b0;
                        `CTM_IO_HIGH: next_out = 1'b1;
                        `CTM_IO_TOGGLE: next_out = ~out_q;
                        default: next_out = out_q;
                    endcase
                end
            end
            CTM_MODE_PWM_E: begin
                case (out_func_in)
                    `CTM_PWM_INACTIVE: next_out = ~out_ctrl_in;
                    `CTM_PWM_ACTIVE: next_out = out_ctrl_in;
                    `CTM_PWM_WAVE: begin
                        if (advance) begin
                            next_out = pwm_on ? out_ctrl_in : ~out_ctrl_in;
                        end
                    end
                    default: next_out = out_q;
                endcase
            end
            default: next_out = out_q;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            out_q <= 1'b0;
        end else if (ce_in) begin
            if (run_rise && mode != CTM_MODE_TIMER_E) begin
                out_q <= out_ctrl_in;
            end else begin
                out_q <= next_out;
            end
        end
    end

    // ****************************************************************
    // Output pins
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            pin <= 1'b0;
            pin_inv <= 1'b1;
        end else if (ce_in) begin
            pin <= out_q ^ out_pol_in;
            pin_inv <= ~(out_q ^ out_pol_in);
        end
    end

    assign timer_out_pin_out = pin;
    assign timer_out_pin_inverted_out = pin_inv;
endmodule : ctm_top

// ===== bench/ctm_far_end.sv
// Far-side model: free sub clock and burst-driven event pin
`timescale 1ns/1ns
module ctm_far_end #(
    parameter int SUB_HALF_NS = 615
) (
    output logic sub_clk_out,  // Free-running sub clock
    output logic event_pin_out // Event clock pin
);
    initial begin
        sub_clk_out = 1'b0;
        event_pin_out = 1'b0;
    end
    always #(SUB_HALF_NS) sub_clk_out = ~sub_clk_out;
    // Pin stands still between bursts; each pulse is one rise, one fall
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            #170 event_pin_out = 1'b1;
            #230 event_pin_out = 1'b0;
        end
    endtask : burst
endmodule : ctm_far_end

// ===== bench/ctm_top_sva.sv
// Port checker for the compact timer
`timescale 1ns/1ns
module ctm_top_sva #(
    parameter int CNT_W = 10,
    parameter int P_W = 3
) (
    input wire logic sys_clk_in,              // Clock
    input wire logic nrst_in,                 // Reset
    input wire logic ce_in,                   // Enable
    input wire logic counter_run_bit_in,      // Run
    input wire logic pause_in,                // Pause
    input wire logic [2:0] clock_select_field_in, // Clock source
    input wire logic [P_W-1:0] compare_p_value_in, // P value
    input wire logic [1:0] mode_in,           // Mode
    input wire logic [1:0] out_func_in,       // Output function
    input wire logic out_ctrl_in,             // Initial level
    input wire logic out_pol_in,              // Polarity
    input wire logic clr_on_a_in,             // Clear select
    input wire logic sub_clk_in,              // Sub clock
    input wire logic event_clock_pin_in,      // Event pin
    input wire logic acc_wr_in,               // Write strobe
    input wire logic acc_rd_in,               // Read strobe
    input wire logic [1:0] acc_sel_in,        // Byte select
    input wire logic [7:0] acc_wdata_in,      // Write data
    input wire logic [7:0] acc_rdata_out,     // Read data
    input wire logic acc_rvalid_out,          // Read valid
    input wire logic irq_a_out,               // A match
    input wire logic irq_p_out,               // P match
    input wire logic timer_out_pin_out,       // Output pin
    input wire logic timer_out_pin_inverted_out, // Inverted pin
    input wire logic [CNT_W-1:0] count_out    // Counter
);
    // ****
    // Port relations
    // ****
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);
    sequence evt_quiet;
        clock_select_field_in[2:1] == 2'b11 && $stable(event_clock_pin_in)
            && counter_run_bit_in && $past(counter_run_bit_in);
    endsequence
    cnt_step_a: assert property ($changed(count_out) |->
        count_out == CNT_W'($past(count_out) + 1'b1) || count_out == '0)
        else $error("counter moved other than by one or to zero");
    run_hold_a: assert property (!counter_run_bit_in && ce_in |=>
        $stable(count_out)) else $error("counter moved while stopped");
    pause_hold_a: assert property (pause_in && counter_run_bit_in
        && $past(counter_run_bit_in) |=> $stable(count_out))
        else $error("counter moved while paused");
    evt_gate_a: assert property (evt_quiet [*5] |=>
        $stable(count_out)) else $error("counter moved without pin edge");
    p_match_a: assert property (irq_p_out |->
        count_out[6:0] == 7'h00) else $error("P request off boundary");
    a_clear_a: assert property (irq_a_out && $past(clr_on_a_in) |->
        count_out == '0) else $error("A match did not clear counter");
    rd_valid_a: assert property (1'b1 |=> acc_rvalid_out ==
        ($past(ce_in) ? $past(acc_rd_in && !acc_wr_in)
        : $past(acc_rvalid_out)))
        else $error("read valid not one cycle after read");
    pin_pair_a: assert property (timer_out_pin_inverted_out ==
        !timer_out_pin_out) else $error("output pins not complementary");
    pin_cause_a: assert property ($changed(timer_out_pin_out)
        && $past(mode_in, 2) == 2'h0 && $past(out_pol_in) ==
        $past(out_pol_in, 2) && $past(counter_run_bit_in, 2) &&
        $past(counter_run_bit_in, 3) && $past(nrst_in) &&
        $past(nrst_in, 2) && $past(nrst_in, 3) |-> $past(irq_a_out))
        else $error("compare pin changed without A match");
    cover property (irq_a_out);
    cover property (irq_p_out);
    cover property (acc_rvalid_out);
endmodule : ctm_top_sva

bind ctm_top ctm_top_sva #(.CNT_W(CNT_W), .P_W(P_W)) u_ctm_top_sva (.*);

// ===== bench/tb_top.sv
// Self-checking bench for the compact timer
`timescale 1ns/1ns
module tb_top;
    logic sys_clk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1;
    logic counter_run_bit_in = 1'b0, pause_in = 1'b0, out_ctrl_in = 1'b0;
    logic out_pol_in = 1'b0, clr_on_a_in = 1'b0;
    logic acc_wr_in = 1'b0, acc_rd_in = 1'b0;
    logic sub_clk_in, event_clock_pin_in;
    logic [2:0] clock_select_field_in = 3'h1, compare_p_value_in = 3'h0;
    logic [1:0] mode_in = 2'h3, out_func_in = 2'h0, acc_sel_in = 2'h0;
    logic [7:0] acc_wdata_in = 8'h00, acc_rdata_out, rd;
    logic acc_rvalid_out, irq_a_out, irq_p_out;
    logic timer_out_pin_out, timer_out_pin_inverted_out;
    logic [9:0] count_out;
    int n_mismatch = 0, total_checks = 0;
    ctm_top u_ctm_top (.*);
    ctm_far_end u_ctm_far_end (.sub_clk_out(sub_clk_in),
        .event_pin_out(event_clock_pin_in));
    always #25 sys_clk_in = ~sys_clk_in;
    // ****
    // Helpers
    // ****
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic check(input logic [10:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : step
    task automatic acc(input logic wr, input logic [1:0] s,
            input logic [7:0] d);
        acc_wr_in = wr;
        acc_rd_in = !wr;
        acc_sel_in = s;
        acc_wdata_in = d;
        step(1);
        if (!wr) check(acc_rvalid_out, 1'b1, "read valid");
        rd = acc_rdata_out;
    endtask : acc
    task automatic idle;
        acc_wr_in = 1'b0;
        acc_rd_in = 1'b0;
        step(1);
    endtask : idle
    task automatic restart;
        counter_run_bit_in = 1'b0;
        step(1);
        counter_run_bit_in = 1'b1;
        step(1);
    endtask : restart
    task automatic wait_irq(input logic is_a, input int bound, output int w);
        for (w = 0; w < bound; w++) begin
            if ((is_a ? irq_a_out : irq_p_out) === 1'b1) break;
            step(1);
        end
        if (w == bound) begin
            n_mismatch++;
            $display("Error at %0t: interrupt wait ran out", $time);
            complete_run();
        end
    endtask : wait_irq
    // ****
    // Scenarios
    // ****
    task automatic t_bytes;
        acc(1'b1, 2'h1, 8'h03);
        acc(1'b1, 2'h2, 8'ha5);
        acc(1'b1, 2'h3, 8'h02);
        acc(1'b1, 2'h2, 8'h33);
        acc(1'b0, 2'h3, 8'h00);
        check(rd, 8'h02, "compare high");
        acc(1'b0, 2'h2, 8'h00);
        check(rd, 8'ha5, "compare low");
        acc(1'b0, 2'h1, 8'h00);
        check(rd, 8'h00, "counter not writable");
        idle();
        $display("Test bytes done");
    endtask : t_bytes
    task automatic t_count;
        restart();
        step(300);
        check(count_out, 10'h12c, "count after run");
        ce_in = 1'b0;
        step(5);
        check(count_out, 10'h12c, "count frozen");
        ce_in = 1'b1;
        pause_in = 1'b1;
        step(20);
        check(count_out, 10'h12c, "count in pause");
        acc(1'b0, 2'h1, 8'h00);
        check(rd, 8'h01, "count high");
        acc(1'b0, 2'h0, 8'h00);
        check(rd, 8'h2c, "count low");
        idle();
        pause_in = 1'b0;
        counter_run_bit_in = 1'b0;
        step(5);
        check(count_out, 10'h12c, "count while off");
        counter_run_bit_in = 1'b1;
        step(1);
        check(count_out, 10'h000, "run rise clears");
        $display("Test count done");
    endtask : t_count
    task automatic t_period;
        logic [2:0] pv[3] = '{3'h1, 3'h3, 3'h0};
        int w;
        foreach (pv[i]) begin
            compare_p_value_in = pv[i];
            restart();
            wait_irq(1'b0, 1100, w);
            step(1);
            wait_irq(1'b0, 1100, w);
            check(w + 1, pv[i] == 0 ? 1024 : pv[i] * 128, "P period");
            check(count_out, 10'h000, "count at P match");
        end
        $display("Test period done");
    endtask : t_period
    task automatic t_cmp;
        logic e;
        int w;
        acc(1'b1, 2'h2, 8'h05);
        acc(1'b1, 2'h3, 8'h00);
        idle();
        mode_in = 2'h0;
        clr_on_a_in = 1'b1;
        compare_p_value_in = 3'h1;
        for (int f = 1; f < 4; f++) begin
            out_func_in = f[1:0];
            out_ctrl_in = f == 1;
            out_pol_in = f == 3;
            e = f == 2;
            restart();
            step(1);
            check(timer_out_pin_out, !e, "pin initial level");
            wait_irq(1'b1, 20, w);
            check(irq_p_out, 1'b0, "P quiet at A match");
            check(count_out, 10'h000, "A match clears");
            step(1);
            check(timer_out_pin_out, e, "pin after match");
            check(timer_out_pin_inverted_out, !e, "inverted pin");
            wait_irq(1'b1, 20, w);
            check(w + 1, 5, "A period");
            step(1);
            check(timer_out_pin_out, f == 3 ? !e : e, "pin next match");
        end
        $display("Test compare done");
    endtask : t_cmp
    task automatic t_pwm;
        int h = 0;
        mode_in = 2'h2;
        out_func_in = 2'h2;
        out_ctrl_in = 1'b1;
        out_pol_in = 1'b0;
        clr_on_a_in = 1'b0;
        restart();
        step(200);
        for (int i = 0; i < 128; i++) begin
            h += timer_out_pin_out === 1'b1;
            step(1);
        end
        check(h, 5, "PWM high cycles");
        for (int f = 0; f < 2; f++) begin
            out_func_in = f[1:0];
            restart();
            step(4);
            check(timer_out_pin_out, f[0], "PWM fixed state");
        end
        mode_in = 2'h3;
        step(300);
        check(timer_out_pin_out, 1'b1, "timer mode holds pin");
        $display("Test PWM done");
    endtask : t_pwm
    task automatic t_clock;
        logic [2:0] cs[3] = '{3'h0, 3'h2, 3'h3};
        int dv[3] = '{4, 16, 64};
        compare_p_value_in = 3'h0;
        foreach (cs[i]) begin
            clock_select_field_in = cs[i];
            restart();
            step(640);
            check(count_out, 640 / dv[i], "divided count");
        end
        for (int s = 4; s < 6; s++) begin
            clock_select_field_in = s[2:0];
            restart();
            step(1000);
            check(count_out >= 40 && count_out <= 41, 1, "sub count");
        end
        $display("Test clock done");
    endtask : t_clock
    task automatic t_event;
        for (int s = 6; s < 8; s++) begin
            clock_select_field_in = s[2:0];
            restart();
            u_ctm_far_end.burst(s);
            step(10);
            check(count_out, s, "event count");
        end
        clock_select_field_in = 3'h3;
        restart();
        u_ctm_far_end.burst(3);
        step(1);
        check(count_out <= 1, 1, "pin ignored");
        $display("Test event done");
    endtask : t_event
    initial begin
        step(16);
        nrst_in = 1'b1;
        t_bytes();
        t_count();
        t_period();
        t_cmp();
        t_pwm();
        t_clock();
        t_event();
        complete_run();
    end
endmodule : tb_top
